// ==== src/ashp_defines.svh ====
// constants for the adc serial host port, both ends
`ifndef ASHP_DEFINES_SVH
`define ASHP_DEFINES_SVH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define ASHP_ADDR_BITS 4
`define ASHP_RES_BITS 10
`define ASHP_UP_CLKS 10
`define ASHP_DSP_CLKS 16
`define ASHP_SAMPLE_EDGE 4
`define ASHP_CONV_EDGE 10
`define ASHP_CNT_MAX 5'h1f

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ASHP_SYS_PERIOD_NS 8
`define ASHP_IO_HALF_NS 64
`define ASHP_IO_HALF_CYC \
    ((`ASHP_IO_HALF_NS + `ASHP_SYS_PERIOD_NS - 1) / `ASHP_SYS_PERIOD_NS)

`endif

// ==== src/ashp_pkg.sv ====
// types shared by both ends of the adc serial host port
package ashp_pkg;

`include "ashp_defines.svh"

    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ASHP_D_IDLE = 2'h0,
        ASHP_D_WAIT_FS = 2'h1,
        ASHP_D_SHIFT = 2'h3
    } ashp_dev_state_t;

    typedef enum logic [1:0] {
        ASHP_H_IDLE = 2'h0,
        ASHP_H_SETUP = 2'h1,
        ASHP_H_SHIFT = 2'h3,
        ASHP_H_END = 2'h2
    } ashp_host_state_t;

    // ----------------------------------------------------------------
    // whole state of each end
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] cs_s;
        logic [1:0] clk_s;
        logic [1:0] din_s;
        logic [1:0] fs_s;
        logic [1:0] mode_s;
        logic [1:0] pol_s;
        logic cs_q;
        logic clk_q;
        logic fs_q;
        ashp_dev_state_t st;
        logic [`ASHP_RES_BITS-1:0] sh;
        logic [`ASHP_ADDR_BITS-1:0] addr;
        logic [2:0] in_cnt;
        logic [4:0] rise_cnt;
        logic [4:0] fall_cnt;
        logic oe;
        logic busy;
        logic samp;
        logic conv_start;
        logic [`ASHP_ADDR_BITS-1:0] conv_addr;
        logic [`ASHP_RES_BITS-1:0] result;
    } ashp_dev_t;

    typedef struct packed {
        ashp_host_state_t st;
        logic cs_n;
        logic fs_n;
        logic clk;
        logic din;
        logic mode;
        logic pol;
        logic pend;
        logic [7:0] div;
        logic [5:0] edge_cnt;
        logic [3:0] bits_in;
        logic [`ASHP_ADDR_BITS-1:0] sh_out;
        logic [`ASHP_RES_BITS-1:0] sh_in;
        logic [1:0] eoc_s;
        logic [1:0] dout_s;
        logic [`ASHP_RES_BITS-1:0] rx_data;
        logic rx_valid;
    } ashp_host_t;

endpackage

// ==== src/ashp_if.sv ====
// pin bundle between the converter port and its host
`timescale 1ns/1ps

interface ashp_if;
    logic cs_n;
    logic io_clk;
    logic data_in;
    logic frame_sync_n;
    logic clock_polarity_select_n;
    logic dsp_mode;
    logic data_out;
    logic data_out_oe;
    logic eoc;
    wire logic data_out_line;

    // released line shows the inverse so a sample taken off the window is caught
    assign data_out_line = data_out_oe ? data_out : ~data_out;

    modport dev (
        input cs_n,
        input io_clk,
        input data_in,
        input frame_sync_n,
        input clock_polarity_select_n,
        input dsp_mode,
        output data_out,
        output data_out_oe,
        output eoc
    );

    modport host (
        output cs_n,
        output io_clk,
        output data_in,
        output frame_sync_n,
        output clock_polarity_select_n,
        output dsp_mode,
        input data_out_line,
        input eoc
    );
endinterface

// ==== src/ashp_dev.sv ====
// converter end of the serial host port
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps

`include "ashp_defines.svh"

module ashp_dev (
    input wire logic clock,
    input wire logic rst,
    ashp_if.dev pins,
    output logic conv_start,
    output logic [`ASHP_ADDR_BITS-1:0] conv_addr,
    output logic sampling,
    input wire logic conv_done,
    input wire logic [`ASHP_RES_BITS-1:0] conv_data
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------

    // edge counters stop at the top so long frames never wrap
    function automatic logic [4:0] sat_inc(input logic [4:0] v);
        sat_inc = (v == `ASHP_CNT_MAX) ? v : v + 5'h1;
    endfunction

    // idle select and sync read high so no false edge after reset
    localparam ashp_pkg::ashp_dev_t DEV_RST = '{
        cs_s: 2'h3,
        clk_s: 2'h0,
        din_s: 2'h0,
        fs_s: 2'h3,
        mode_s: 2'h0,
        pol_s: 2'h3,
        cs_q: 1'b1,
        clk_q: 1'b0,
        fs_q: 1'b1,
        st: ashp_pkg::ASHP_D_IDLE,
        sh: '0,
        addr: '0,
        in_cnt: 3'h0,
        rise_cnt: 5'h0,
        fall_cnt: 5'h0,
        oe: 1'b0,
        busy: 1'b0,
        samp: 1'b0,
        conv_start: 1'b0,
        conv_addr: '0,
        result: '0
    };

    ashp_pkg::ashp_dev_t r;
    ashp_pkg::ashp_dev_t next_r;

    // synchronised pin levels, second stage only
    logic cs_n;
    logic clk_l;
    logic fs_n;
    logic din;
    logic dsp;
    logic pol;
    logic rise;
    logic fall;
    logic cs_fall;
    logic fs_fall;
    logic cap;
    logic start_conv;

    assign cs_n = r.cs_s[1];
    assign clk_l = r.clk_s[1];
    assign fs_n = r.fs_s[1];
    assign din = r.din_s[1];
    assign dsp = r.mode_s[1];
    assign pol = r.pol_s[1];

    assign rise = clk_l & ~r.clk_q;
    assign fall = ~clk_l & r.clk_q;
    assign cs_fall = ~cs_n & r.cs_q;
    assign fs_fall = ~fs_n & r.fs_q;

    // address capture edge flips between the two modes
    assign cap = dsp ? (pol ? fall : rise) : (pol ? rise : fall);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_r = r;
        start_conv = 1'b0;
        next_r.conv_start = 1'b0;

        // two flip-flops on every pin from the host
        next_r.cs_s = {r.cs_s[0], pins.cs_n};
        next_r.clk_s = {r.clk_s[0], pins.io_clk};
        next_r.din_s = {r.din_s[0], pins.data_in};
        next_r.fs_s = {r.fs_s[0], pins.frame_sync_n};
        next_r.mode_s = {r.mode_s[0], pins.dsp_mode};
        next_r.pol_s = {r.pol_s[0], pins.clock_polarity_select_n};
        next_r.cs_q = cs_n;
        next_r.clk_q = clk_l;
        next_r.fs_q = fs_n;

        if (cs_n) begin
            // deselected: clock and data in are ignored
            next_r.st = ashp_pkg::ASHP_D_IDLE;
            next_r.oe = 1'b0;
        end else if (cs_fall) begin
            // abort the frame in flight, keep the held result and any running conversion
            next_r.oe = 1'b1;
            next_r.sh = r.result;
            next_r.in_cnt = 3'h0;
            next_r.rise_cnt = 5'h0;
            next_r.fall_cnt = 5'h0;
            next_r.samp = 1'b0;
            next_r.st = dsp ? ashp_pkg::ASHP_D_WAIT_FS : ashp_pkg::ASHP_D_SHIFT;
            if (dsp) begin
                next_r.sh = '0;
            end
        end else if (dsp) begin
            if (!fs_n && fs_fall) begin
                next_r.st = ashp_pkg::ASHP_D_SHIFT;
                next_r.sh = r.result;
                next_r.in_cnt = 3'h0;
                next_r.rise_cnt = 5'h0;
                next_r.fall_cnt = 5'h0;
            end else if (fs_n) begin
                // sync high holds the machine at frame start
                if (fall) begin
                    next_r.st = ashp_pkg::ASHP_D_WAIT_FS;
                    next_r.in_cnt = 3'h0;
                    next_r.rise_cnt = 5'h0;
                    next_r.fall_cnt = 5'h0;
                end
                if (rise) begin
                    next_r.st = ashp_pkg::ASHP_D_WAIT_FS;
                end
            end else if (r.st == ashp_pkg::ASHP_D_SHIFT) begin
                if (cap && r.in_cnt < 3'(`ASHP_ADDR_BITS)) begin
                    next_r.addr = {r.addr[`ASHP_ADDR_BITS-2:0], din};
                    next_r.in_cnt = r.in_cnt + 3'h1;
                end
                if (rise) begin
                    // zero fill pads the frame after the result
                    next_r.sh = {r.sh[`ASHP_RES_BITS-2:0], 1'b0};
                    next_r.rise_cnt = sat_inc(r.rise_cnt);
                    if (r.rise_cnt == 5'(`ASHP_SAMPLE_EDGE - 1)) begin
                        next_r.samp = 1'b1;
                    end
                end
                if (fall) begin
                    next_r.fall_cnt = sat_inc(r.fall_cnt);
                    if (r.fall_cnt == 5'(`ASHP_CONV_EDGE - 1)) begin
                        start_conv = 1'b1;
                    end
                end
            end
        end else if (r.st == ashp_pkg::ASHP_D_SHIFT) begin
            if (cap && r.in_cnt < 3'(`ASHP_ADDR_BITS)) begin
                next_r.addr = {r.addr[`ASHP_ADDR_BITS-2:0], din};
                next_r.in_cnt = r.in_cnt + 3'h1;
            end
            if (fall) begin
                // tenth fall leaves only zero fill on the line
                next_r.sh = {r.sh[`ASHP_RES_BITS-2:0], 1'b0};
                next_r.fall_cnt = sat_inc(r.fall_cnt);
                if (r.fall_cnt == 5'(`ASHP_SAMPLE_EDGE - 1)) begin
                    next_r.samp = 1'b1;
                end
            end
            if (rise) begin
                next_r.rise_cnt = sat_inc(r.rise_cnt);
                if (r.rise_cnt == 5'(`ASHP_CONV_EDGE - 1)) begin
                    start_conv = 1'b1;
                end
            end
        end

        // ----------------------------------------------------------------
        // conversion handoff
        // ----------------------------------------------------------------
        if (conv_done) begin
            next_r.busy = 1'b0;
            next_r.result = conv_data;
        end
        // a start in the same cycle as done wins
        if (start_conv) begin
            next_r.busy = 1'b1;
            next_r.conv_start = 1'b1;
            next_r.samp = 1'b0;
            next_r.conv_addr = next_r.addr;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            r <= DEV_RST;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign pins.data_out = r.sh[`ASHP_RES_BITS-1];
    assign pins.data_out_oe = r.oe;
    assign pins.eoc = ~r.busy;
    assign conv_start = r.conv_start;
    assign conv_addr = r.conv_addr;
    assign sampling = r.samp;

endmodule // ashp_dev

// ==== src/ashp_host.sv ====
// host end of the serial host port: makes clock, select and sync
`timescale 1ns/1ps

`include "ashp_defines.svh"

module ashp_host (
    input wire logic clock,
    input wire logic rst,
    ashp_if.host pins,
    input wire logic start,
    input wire logic [`ASHP_ADDR_BITS-1:0] start_addr,
    input wire logic dsp_mode,
    input wire logic polarity_n,
    output logic busy,
    output logic [`ASHP_RES_BITS-1:0] rx_data,
    output logic rx_valid
);

    localparam logic [7:0] HALF = 8'(`ASHP_IO_HALF_CYC);

    ashp_pkg::ashp_host_t r;
    ashp_pkg::ashp_host_t next_r;

    logic tick;
    logic gen_rise;
    logic cap_rise;
    logic [5:0] last_edge;

    assign tick = (r.div == HALF - 8'h1);
    assign gen_rise = ~r.clk;
    assign cap_rise = r.mode ? ~r.pol : r.pol;
    // dsp frames run sixteen clocks, micro frames ten
    assign last_edge = r.mode ? 6'(2 * `ASHP_DSP_CLKS - 1)
        : 6'(2 * `ASHP_UP_CLKS - 1);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.rx_valid = 1'b0;
        next_r.eoc_s = {r.eoc_s[0], pins.eoc};
        next_r.dout_s = {r.dout_s[0], pins.data_out_line};
        next_r.div = tick ? 8'h0 : r.div + 8'h1;

        case (r.st)
            ashp_pkg::ASHP_H_IDLE: begin
                next_r.div = 8'h0;
                // dsp clock idles high so the first edge samples the msb
                next_r.clk = dsp_mode;
                // wait for the last conversion before reading again
                if (start && r.eoc_s[1]) begin
                    next_r.mode = dsp_mode;
                    next_r.pol = polarity_n;
                    next_r.cs_n = 1'b0;
                    next_r.sh_out = start_addr;
                    next_r.din = start_addr[`ASHP_ADDR_BITS-1];
                    next_r.edge_cnt = 6'h0;
                    next_r.bits_in = 4'h0;
                    next_r.pend = 1'b0;
                    next_r.st = ashp_pkg::ASHP_H_SETUP;
                end
            end
            ashp_pkg::ASHP_H_SETUP: begin
                if (tick) begin
                    if (r.mode && r.fs_n) begin
                        next_r.fs_n = 1'b0;
                    end else begin
                        next_r.st = ashp_pkg::ASHP_H_SHIFT;
                    end
                end
            end
            ashp_pkg::ASHP_H_SHIFT: begin
                if (tick) begin
                    next_r.clk = ~r.clk;
                    next_r.edge_cnt = r.edge_cnt + 6'h1;
                    if (gen_rise == cap_rise) begin
                        next_r.pend = 1'b1;
                    end else if (r.pend) begin
                        // change data one edge after the device took it
                        next_r.pend = 1'b0;
                        next_r.sh_out = {r.sh_out[`ASHP_ADDR_BITS-2:0], 1'b0};
                        next_r.din = r.sh_out[`ASHP_ADDR_BITS-2];
                    end
                    if ((gen_rise ^ r.mode) && r.bits_in < 4'(`ASHP_RES_BITS)) begin
                        next_r.sh_in = {r.sh_in[`ASHP_RES_BITS-2:0], r.dout_s[1]};
                        next_r.bits_in = r.bits_in + 4'h1;
                    end
                    if (r.edge_cnt == last_edge) begin
                        next_r.st = ashp_pkg::ASHP_H_END;
                    end
                end
            end
            ashp_pkg::ASHP_H_END: begin
                if (tick) begin
                    next_r.cs_n = 1'b1;
                    next_r.fs_n = 1'b1;
                    next_r.rx_data = r.sh_in;
                    next_r.rx_valid = 1'b1;
                    next_r.st = ashp_pkg::ASHP_H_IDLE;
                end
            end
            default: begin
                next_r.st = ashp_pkg::ASHP_H_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            r <= '0;
            r.st <= ashp_pkg::ASHP_H_IDLE;
            r.cs_n <= 1'b1;
            r.fs_n <= 1'b1;
            r.pol <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign pins.cs_n = r.cs_n;
    assign pins.frame_sync_n = r.fs_n;
    assign pins.io_clk = r.clk;
    assign pins.data_in = r.din;
    assign pins.dsp_mode = r.mode;
    assign pins.clock_polarity_select_n = r.pol;
    assign busy = (r.st != ashp_pkg::ASHP_H_IDLE);
    assign rx_data = r.rx_data;
    assign rx_valid = r.rx_valid;

endmodule // ashp_host

// ==== tb/ashp_sva.sv ====
// concurrent checks on the link between the converter port and its host
`timescale 1ns/1ps

module ashp_sva (
    input wire logic clock,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic io_clk,
    input wire logic data_in,
    input wire logic frame_sync_n,
    input wire logic clock_polarity_select_n,
    input wire logic dsp_mode,
    input wire logic data_out,
    input wire logic data_out_oe,
    input wire logic eoc
);
    logic io_q;
    logic cs_q;
    logic fs_q;
    logic [4:0] rise_cnt;
    logic [4:0] fall_cnt;
    logic [3:0] quiet;
    logic io_rise;
    logic io_fall;
    logic live;
    logic evt;

    // ----------------------------------------------------------------
    // edge counting
    // ----------------------------------------------------------------
    assign io_rise = io_clk & ~io_q;
    assign io_fall = ~io_clk & io_q;
    // in dsp mode edges only count once frame sync is low
    assign live = ~cs_n & (~dsp_mode | ~frame_sync_n);
    assign evt = (dsp_mode ? io_rise : io_fall) | (cs_n ^ cs_q) | (~frame_sync_n & fs_q);

    always_ff @(posedge clock) begin
        io_q <= rst ? 1'b0 : io_clk;
        cs_q <= rst ? 1'b1 : cs_n;
        fs_q <= rst ? 1'b1 : frame_sync_n;
        rise_cnt <= (rst | ~live) ? 5'h00 : rise_cnt + {4'h0, io_rise};
        fall_cnt <= (rst | ~live) ? 5'h00 : fall_cnt + {4'h0, io_fall};
        // saturates so a long idle never wraps into the window
        quiet <= (rst | evt) ? 4'h0 : (quiet == 4'hf ? quiet : quiet + 4'h1);
    end

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence zero_tail_s;
        !data_out [*3];
    endsequence

    sequence micro_tenth_fall_s;
        !dsp_mode && !cs_n && io_fall && fall_cnt == 5'h09;
    endsequence

    oe_on_a: assert property ($fell(cs_n) |-> ##[1:5] data_out_oe)
        else $error("output not enabled after select");
    oe_off_a: assert property ($rose(cs_n) |-> ##[1:5] !data_out_oe)
        else $error("output not released after select");
    oe_idle_a: assert property (cs_n [*8] |-> !data_out_oe)
        else $error("output driven while deselected");
    eoc_sel_a: assert property ($fell(eoc) |-> !cs_n)
        else $error("conversion started while deselected");
    eoc_micro_a: assert property ((!dsp_mode && !cs_n && io_rise && rise_cnt == 5'h09)
        |-> ##[1:6] !eoc)
        else $error("eoc not low after tenth rise");
    eoc_dsp_a: assert property ((dsp_mode && !cs_n && !frame_sync_n && io_fall
        && fall_cnt == 5'h09) |-> ##[1:6] !eoc)
        else $error("eoc not low after tenth fall");
    eoc_early_a: assert property ($fell(eoc)
        |-> (dsp_mode ? fall_cnt == 5'h0a : rise_cnt == 5'h0a))
        else $error("conversion started on wrong edge");
    micro_tail_a: assert property (micro_tenth_fall_s |-> ##4 zero_tail_s)
        else $error("output not forced low after tenth fall");
    dsp_tail_a: assert property ((dsp_mode && !cs_n && !frame_sync_n && io_rise
        && rise_cnt == 5'h09) |-> ##4 zero_tail_s)
        else $error("dsp tail bits not zero");
    shift_edge_a: assert property ((data_out_oe && $changed(data_out))
        |-> quiet < 4'h6)
        else $error("output changed away from its shift edge");
endmodule // ashp_sva

// ==== tb/adc_serial_host_port_tb_top.sv ====
// self-checking bench: host and converter port joined, plus a hand-driven port
`timescale 1ns/1ps

module adc_serial_host_port_tb_top;
    logic clock;
    logic rst;
    logic start;
    logic [3:0] start_addr;
    logic dsp_mode;
    logic polarity_n;
    logic busy;
    logic [9:0] rx_data;
    logic rx_valid;
    logic conv_start;
    logic [3:0] conv_addr;
    logic conv_done;
    logic [9:0] conv_data;
    logic conv_start_b;
    logic [3:0] conv_addr_b;
    logic conv_done_b;
    logic sampling;
    logic samp_seen;
    logic [4:0] cdly;
    logic [3:0] exp_addr;
    logic [11:0] rd;
    logic [9:0] prev;
    logic [9:0] res_v [0:3] = '{10'h2a5, 10'h15a, 10'h3c3, 10'h0f1};
    logic [3:0] addr_v [0:3] = '{4'h9, 4'h6, 4'hc, 4'h3};
    int n_b;
    int err_count;
    int cmp_count;

    ashp_if u_ashp_if();
    ashp_if u_ashp_if_b();

    ashp_host u_ashp_host (.clock(clock), .rst(rst), .pins(u_ashp_if.host), .start(start),
        .start_addr(start_addr), .dsp_mode(dsp_mode), .polarity_n(polarity_n), .busy(busy),
        .rx_data(rx_data), .rx_valid(rx_valid));
    ashp_dev u_ashp_dev (.clock(clock), .rst(rst), .pins(u_ashp_if.dev),
        .conv_start(conv_start), .conv_addr(conv_addr), .sampling(sampling),
        .conv_done(conv_done),
        .conv_data(conv_data));
    // second port driven by hand, so aborts and stray clocks can be forced
    ashp_dev u_ashp_dev_b (.clock(clock), .rst(rst), .pins(u_ashp_if_b.dev),
        .conv_start(conv_start_b), .conv_addr(conv_addr_b), .sampling(),
        .conv_done(conv_done_b), .conv_data(10'h36c));
    ashp_sva u_ashp_sva (.clock(clock), .rst(rst), .cs_n(u_ashp_if.cs_n),
        .io_clk(u_ashp_if.io_clk), .data_in(u_ashp_if.data_in),
        .frame_sync_n(u_ashp_if.frame_sync_n),
        .clock_polarity_select_n(u_ashp_if.clock_polarity_select_n),
        .dsp_mode(u_ashp_if.dsp_mode), .data_out(u_ashp_if.data_out),
        .data_out_oe(u_ashp_if.data_out_oe), .eoc(u_ashp_if.eoc));

    // ----------------------------------------------------------------
    // reporting
    // ----------------------------------------------------------------
    task automatic complete_run();
        if (err_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bail(input int n);
        if (n >= 3000) begin
            err_count++;
            complete_run();
        end
    endtask

    // ----------------------------------------------------------------
    // conversion engine stand-in: done after a fixed delay
    // ----------------------------------------------------------------
    always @(negedge clock) begin
        conv_done <= 1'b0;
        conv_done_b <= conv_start_b;
        // acquire window must have opened before the conversion takes over
        samp_seen <= (conv_start === 1'b1) ? 1'b0 : (samp_seen | (sampling === 1'b1));
        if (conv_start_b === 1'b1) begin
            n_b++;
        end
        if (conv_start === 1'b1) begin
            check({8'h00, conv_addr}, {8'h00, exp_addr});
            check({10'h000, samp_seen, sampling}, 12'h002);
            cdly <= 5'h14;
        end else if (cdly != 5'h00) begin
            cdly <= cdly - 5'h01;
            if (cdly == 5'h01) begin
                check({11'h000, u_ashp_if.eoc}, 12'h000);
                conv_done <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic xfer(input logic [3:0] a, input logic m, input logic p,
        input logic [9:0] nxt, input logic [9:0] exp);
        int n;
        exp_addr = a;
        conv_data = nxt;
        start_addr = a;
        dsp_mode = m;
        polarity_n = p;
        // idle clock level follows the mode; let it settle before select falls
        repeat (2) @(negedge clock);
        start = 1'b1;
        @(negedge clock);
        start = 1'b0;
        n = 0;
        while (rx_valid !== 1'b1 && n < 3000) begin
            @(negedge clock);
            n++;
        end
        bail(n);
        check({2'b00, rx_data}, {2'b00, exp});
        n = 0;
        while ((busy !== 1'b0 || u_ashp_if.eoc !== 1'b1) && n < 3000) begin
            @(negedge clock);
            n++;
        end
        bail(n);
        repeat (4) @(negedge clock);
    endtask

    // clock halves of four cycles give a 64 ns link period
    task automatic bb_xfer(input logic [3:0] a, input int n);
        rd = 12'h000;
        u_ashp_if_b.cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            u_ashp_if_b.data_in = (i < 4) ? a[3 - i] : 1'b0;
            repeat (4) @(negedge clock);
            u_ashp_if_b.io_clk = 1'b1;
            repeat (4) @(negedge clock);
            rd = {rd[10:0], u_ashp_if_b.data_out_line};
            u_ashp_if_b.io_clk = 1'b0;
        end
        repeat (4) @(negedge clock);
        u_ashp_if_b.cs_n = 1'b1;
        repeat (8) @(negedge clock);
    endtask

    // ----------------------------------------------------------------
    // stimulus
    // ----------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    initial begin
        rst = 1'b1;
        start = 1'b0;
        start_addr = 4'h0;
        dsp_mode = 1'b0;
        polarity_n = 1'b1;
        conv_data = 10'h000;
        cdly = 5'h00;
        samp_seen = 1'b0;
        u_ashp_if_b.cs_n = 1'b1;
        u_ashp_if_b.io_clk = 1'b0;
        u_ashp_if_b.data_in = 1'b0;
        u_ashp_if_b.frame_sync_n = 1'b1;
        u_ashp_if_b.clock_polarity_select_n = 1'b1;
        u_ashp_if_b.dsp_mode = 1'b0;
        repeat (8) @(negedge clock);
        rst = 1'b0;
        repeat (4) @(negedge clock);
        prev = 10'h000;
        for (int i = 0; i < 4; i++) begin
            xfer(addr_v[i], i[1], i[0], res_v[i], prev);
            prev = res_v[i];
        end
        xfer(4'h5, 1'b0, 1'b1, 10'h000, prev);
        bb_xfer(4'h5, 10);
        check(rd, 12'h000);
        check({8'h00, conv_addr_b}, 12'h005);
        bb_xfer(4'ha, 3);
        // stray clocks and data while deselected must be ignored
        u_ashp_if_b.data_in = 1'b1;
        repeat (24) begin
            repeat (4) @(negedge clock);
            u_ashp_if_b.io_clk = ~u_ashp_if_b.io_clk;
        end
        check({11'h000, u_ashp_if_b.eoc}, 12'h001);
        check(n_b[11:0], 12'h001);
        bb_xfer(4'h3, 12);
        check(rd, {10'h36c, 2'b00});
        check({8'h00, conv_addr_b}, 12'h003);
        check(n_b[11:0], 12'h002);
        complete_run();
    end
endmodule // adc_serial_host_port_tb_top
